// *** verilog/fps_map.vh ***
// fps_map.vh: opcodes, bit counts, page size, timing figures of the program/erase sequencer
// assumes: included by fps_core.v only
`ifndef FPS_MAP_VH
`define FPS_MAP_VH
`define FPS_OP_WREN 8'h06
`define FPS_OP_WRDI 8'h04
`define FPS_OP_WRSR 8'h01
`define FPS_OP_PP 8'h02
`define FPS_OP_QPP 8'h32
`define FPS_OP_QPP4 8'h42
`define FPS_OP_SE 8'h20
`define FPS_OP_BE32 8'h52
`define FPS_OP_BE64 8'hD8
`define FPS_OP_CE1 8'hC7
`define FPS_OP_CE2 8'h60
`define FPS_OP_SECR 8'h44
`define FPS_OP_SUSP 8'h75
`define FPS_OP_RESM 8'h7A
`define FPS_ERASED 8'hFF
`define FPS_PAGE_BYTES 256
`define FPS_OP_BITS 6'h08
`define FPS_ADR_BITS 6'h20
`define FPS_RESUME_NS 200
`define FPS_CLK_NS 10
`endif

// *** verilog/fps_core.v ***
// fps_core.v: program, erase and suspend command handling of a serial nor flash
// assumes: link pins are asynchronous to clk and far slower than it (link clock >= 8 clk periods);
// the array itself is external and driven by the op_* outputs.
//
// Overview of operation
// - quad program needs quad enable and write latch
// - quad program writes at most one 256-byte page
// - quad program refused in four-line command mode
// - 20h erases addressed 4 KB sector
// - 52h erases addressed 32 KB block
// - D8h erases addressed 64 KB block
// - C7h or 60h erases whole array
// - erases refused unless write latch set
// - sector/block erase needs select rise after address
// - chip erase needs select rise after opcode
// - busy held during self-timed erase, status served
// - write latch cleared when program/erase completes
// - protected sector/block erase is suppressed
// - chip erase suppressed if anything protected
// - suspend only when idle flag, busy, erase/program
// - suspend ignored during chip erase
// - suspend sets flag now, busy drops within latency
// - erase suspended refuses status write and erases
// - program suspended refuses status write and programs
// - program suspend only for page programs
// - reset leaves device out of suspend
// - resume needs flag set, busy clear; busy within 200ns
// - program data wraps within the 256-byte page
`timescale 1ns/100ps
`default_nettype none
`include "fps_map.vh"
module fps_core #(
  parameter ERASE_CYCLES = 32'd100000,   // self-timed erase length
  parameter CHIP_CYCLES = 32'd400000,    // self-timed chip erase length
  parameter PROG_CYCLES = 32'd5000,      // self-timed program length
  parameter SUSPEND_CYCLES = 32'd2000    // suspend latency in clk cycles
) (
  input wire clk,                        // 100 MHz system clock
  input wire arst_n,                     // async reset, low active
  input wire chip_select_n,              // link select, low active
  input wire serial_clock,               // link clock from host
  input wire data_line_0,                // link data line 0
  input wire data_line_1,                // link data line 1
  input wire data_line_2,                // link data line 2
  input wire data_line_3,                // link data line 3
  input wire quad_enable_bit,            // quad enable status bit
  input wire four_line_command_mode,     // four-line command mode active
  input wire protect_complement,         // protection complement bit
  input wire sector_granularity_select,  // protection granularity bit
  input wire top_bottom_select,          // protection top/bottom bit
  input wire block_protect_level_2,      // block protect bit 2
  input wire block_protect_level_1,      // block protect bit 1
  input wire block_protect_level_0,      // block protect bit 0
  input wire [22:0] array_top,           // highest array byte address
  output reg busy,                       // self-timed cycle running
  output reg write_enable_latch,         // write enable latch
  output reg suspend_flag,               // operation suspended
  output reg op_erase,                   // erase pulse to array
  output reg [23:0] op_base,             // erase base or program address
  output reg [23:0] op_span,             // erase span minus one
  output reg op_write,                   // program byte pulse to array
  output reg [7:0] op_data,              // program byte
  output reg status_write_refused        // status write blocked while suspended
);
  // ----------------------------------------------------------------
  // link synchronisers
  // ----------------------------------------------------------------
  reg [2:0] cs_s, ck_s;
  reg [3:0] d1, d2, d3;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      d1 <= 4'h0;
      d2 <= 4'h0;
      d3 <= 4'h0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], chip_select_n};
      ck_s <= {ck_s[1:0], serial_clock};
      d1 <= {data_line_3, data_line_2, data_line_1, data_line_0};
      d2 <= d1;
      d3 <= d2;
    end
  end
  reg cs_q, ck_q;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_q <= 1'b1;
      ck_q <= 1'b0;
    end
    else
    begin
      if (cs_s[1] == cs_s[2])
        cs_q <= cs_s[2];
      if (ck_s[1] == ck_s[2])
        ck_q <= ck_s[2];
    end
  end
  wire ck_agree = (ck_s[1] == ck_s[2]);
  wire ck_rise = ck_agree && ck_s[2] && !ck_q && !cs_q;
  wire cs_fall = (cs_s[1] == cs_s[2]) && !cs_s[2] && cs_q;
  wire cs_rise = (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_q;

  // ----------------------------------------------------------------
  // command shifter
  // ----------------------------------------------------------------
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [7:0] dbyte;
  reg [5:0] nbits;       // opcode + address bits seen
  reg [3:0] dbits;       // data nibbles in current byte
  reg quad_ok;
  reg [7:0] page_off;
  reg prog_seen;
  wire in_quad = (opcode == `FPS_OP_QPP) && quad_ok && (nbits == `FPS_ADR_BITS);
  wire [7:0] cur_shift = {opcode[6:0], d3[0]};
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opcode <= 8'h00;
      addr <= 24'h000000;
      dbyte <= 8'h00;
      nbits <= 6'h00;
      dbits <= 4'h0;
      op_write <= 1'b0;
      op_data <= 8'h00;
      page_off <= 8'h00;
      prog_seen <= 1'b0;
    end
    else
    begin
      op_write <= 1'b0;
      if (cs_fall)
      begin
        nbits <= 6'h00;
        dbits <= 4'h0;
        prog_seen <= 1'b0;
      end
      else if (ck_rise)
      begin
        if (nbits < `FPS_OP_BITS)
        begin
          opcode <= cur_shift;
          nbits <= nbits + 6'h01;
        end
        else if (nbits < `FPS_ADR_BITS)
        begin
          addr <= {addr[22:0], d3[0]};
          nbits <= nbits + 6'h01;
          if (nbits == `FPS_ADR_BITS - 6'h01)
            page_off <= {addr[6:0], d3[0]};
        end
        else if (in_quad)
        begin
          dbyte <= {dbyte[3:0], d3};
          if (dbits == 4'h1)
          begin
            dbits <= 4'h0;
            op_write <= 1'b1;
            op_data <= {dbyte[3:0], d3};
            prog_seen <= 1'b1;
            page_off <= page_off + 8'h01;
          end
          else
            dbits <= dbits + 4'h1;
        end
        else
          nbits <= `FPS_ADR_BITS + 6'h01; // overrun marks a bad termination
      end
    end
  end

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  wire [2:0] bp = {block_protect_level_2, block_protect_level_1, block_protect_level_0};
  reg [23:0] pr_lo, pr_hi;
  reg pr_none;
  reg [23:0] psz;
  always @*
  begin
    psz = sector_granularity_select ? (24'h001000 << (bp[1:0] == 2'h3 ? 2'h2 : bp[1:0] - 2'h1))
                                    : (24'h020000 << (bp - 3'h1));
    if (sector_granularity_select && bp[2] == 1'b1)
      psz = 24'h008000;
    pr_none = (bp == 3'h0);
    if (bp == 3'h7)
      psz = {1'b0, array_top} + 24'h000001;
    if (top_bottom_select)
    begin
      pr_lo = 24'h000000;
      pr_hi = psz - 24'h000001;
    end
    else
    begin
      pr_lo = {1'b0, array_top} + 24'h000001 - psz;
      pr_hi = {1'b0, array_top};
    end
  end
  // region [lo,hi] touches protected area (complement inverts coverage)
  function prot;
    input [23:0] lo;
    input [23:0] hi;
    reg hit;
    begin
      hit = !pr_none && !(hi < pr_lo || lo > pr_hi);
      prot = protect_complement ? !(!pr_none && lo >= pr_lo && hi <= pr_hi) : hit;
    end
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_SUSP = 4'b0100;
  localparam ST_HALT = 4'b1000;
  localparam K_PROG = 2'h0;
  localparam K_ERASE = 2'h1;
  localparam K_CHIP = 2'h2;
  localparam [31:0] RESUME_CYC = (`FPS_RESUME_NS / `FPS_CLK_NS);
  reg [3:0] state;
  reg [1:0] kind;
  reg [31:0] remain;
  reg [31:0] lat;
  reg [23:0] mask;
  reg [23:0] r_lo, r_hi;
  always @*
  begin
    case (opcode)
      `FPS_OP_SE: mask = 24'h000FFF;
      `FPS_OP_BE32: mask = 24'h007FFF;
      default: mask = 24'h00FFFF;
    endcase
    r_lo = addr & ~mask;
    r_hi = addr | mask;
  end
  wire is_blk = (opcode == `FPS_OP_SE) || (opcode == `FPS_OP_BE32) || (opcode == `FPS_OP_BE64);
  wire is_chip = (opcode == `FPS_OP_CE1) || (opcode == `FPS_OP_CE2);
  wire is_pgm = (opcode == `FPS_OP_PP) || (opcode == `FPS_OP_QPP) || (opcode == `FPS_OP_QPP4);
  wire is_ers = is_blk || is_chip || (opcode == `FPS_OP_SECR);
  wire at_op = (nbits == `FPS_OP_BITS);
  wire at_adr = (nbits == `FPS_ADR_BITS);
  wire susp_blocks = suspend_flag && ((opcode == `FPS_OP_WRSR) ||
                     (kind == K_ERASE ? is_ers : is_pgm));
  wire prog_page_prot = prot({addr[23:8], 8'h00}, {addr[23:8], 8'hFF});
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      kind <= K_PROG;
      busy <= 1'b0;
      write_enable_latch <= 1'b0;
      suspend_flag <= 1'b0;
      op_erase <= 1'b0;
      op_base <= 24'h000000;
      op_span <= 24'h000000;
      remain <= 32'h00000000;
      lat <= 32'h00000000;
      quad_ok <= 1'b0;
      status_write_refused <= 1'b0;
    end
    else
    begin
      op_erase <= 1'b0;
      status_write_refused <= 1'b0;
      if (cs_fall)
        quad_ok <= 1'b0;
      if (ck_rise && nbits == `FPS_OP_BITS - 6'h01)
        quad_ok <= quad_enable_bit && write_enable_latch && !four_line_command_mode
                   && !(suspend_flag && kind == K_PROG) && (state != ST_RUN);
      if (in_quad && ck_rise && dbits == 4'h0)
        op_base <= {addr[23:8], page_off};
      case (state)
        ST_IDLE, ST_SUSP:
        begin
          if (cs_rise && at_op && opcode == `FPS_OP_WREN)
            write_enable_latch <= 1'b1;
          if (cs_rise && at_op && opcode == `FPS_OP_WRDI)
            write_enable_latch <= 1'b0;
          if (cs_rise && susp_blocks && opcode == `FPS_OP_WRSR)
            status_write_refused <= 1'b1;
          if (state == ST_SUSP && cs_rise && at_op && opcode == `FPS_OP_RESM && !busy)
          begin
            suspend_flag <= 1'b0;
            lat <= RESUME_CYC;
            state <= ST_HALT;
          end
          else if (cs_rise && at_adr && is_blk && write_enable_latch && !susp_blocks
                   && !prot(r_lo, r_hi))
          begin
            op_erase <= 1'b1;
            op_base <= r_lo;
            op_span <= mask;
            kind <= K_ERASE;
            remain <= ERASE_CYCLES;
            busy <= 1'b1;
            state <= ST_RUN;
          end
          else if (cs_rise && at_op && is_chip && write_enable_latch && !susp_blocks
                   && !prot(24'h000000, {1'b0, array_top}))
          begin
            op_erase <= 1'b1;
            op_base <= 24'h000000;
            op_span <= {1'b0, array_top};
            kind <= K_CHIP;
            remain <= CHIP_CYCLES;
            busy <= 1'b1;
            state <= ST_RUN;
          end
          else if (cs_rise && in_quad && prog_seen && dbits == 4'h0 && !prog_page_prot)
          begin
            kind <= K_PROG;
            remain <= PROG_CYCLES;
            busy <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (lat != 32'h00000000)
          begin
            lat <= lat - 32'h00000001;
            if (lat == 32'h00000001)
            begin
              busy <= 1'b0;
              state <= ST_SUSP;
            end
          end
          else if (cs_rise && at_op && opcode == `FPS_OP_SUSP && !suspend_flag
                   && kind != K_CHIP)
          begin
            suspend_flag <= 1'b1;
            lat <= SUSPEND_CYCLES;
          end
          else if (remain <= 32'h00000001)
          begin
            busy <= 1'b0;
            write_enable_latch <= 1'b0;
            state <= ST_IDLE;
          end
          else
            remain <= remain - 32'h00000001;
        end
        ST_HALT:
        begin
          lat <= lat - 32'h00000001;
          if (lat <= 32'h00000001)
          begin
            busy <= 1'b1;
            lat <= 32'h00000000;
            state <= ST_RUN;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dv/fps_core_sva.sv ***
// fps_core_sva.sv: port assertions for fps_core
// assumes: bound to fps_core, one clock domain
`timescale 1ns/100ps
`default_nettype none
module fps_sva #(
  parameter SUSPEND_CYCLES = 32'd2000 // suspend latency in clk cycles
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low active
  input wire logic busy, // cycle running
  input wire logic write_enable_latch, // write latch
  input wire logic suspend_flag, // suspended
  input wire logic quad_enable_bit, // quad enable
  input wire logic four_line_command_mode, // four-line mode
  input wire logic op_erase, // erase pulse
  input wire logic [23:0] op_base, // erase base
  input wire logic [23:0] op_span, // erase mask
  input wire logic op_write, // program pulse
  input wire logic status_write_refused // refusal pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // cycles that busy has stood while the suspend flag is set
  logic [31:0] hold_cnt;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hold_cnt <= 32'h00000000;
    else if (suspend_flag && busy)
      hold_cnt <= hold_cnt + 32'h00000001;
    else
      hold_cnt <= 32'h00000000;
  end
  a_erase_needs_latch: assert property (op_erase |-> write_enable_latch)
    else $error("erase without write latch");
  a_quad_gate: assert property (op_write |-> write_enable_latch && quad_enable_bit && !four_line_command_mode)
    else $error("program byte not allowed");
  a_erase_busy: assert property (op_erase |-> ##[0:2] busy)
    else $error("busy missing after erase start");
  a_done_clears_latch: assert property ($fell(busy) && !suspend_flag |-> ##[0:1] !write_enable_latch)
    else $error("write latch kept after cycle");
  a_suspend_drop: assert property (hold_cnt <= SUSPEND_CYCLES + 32'd1)
    else $error("busy held past suspend latency");
  a_suspend_cause: assert property ($rose(suspend_flag) |-> $past(busy))
    else $error("suspend while idle");
  a_resume_busy: assert property ($fell(suspend_flag) |-> ##[1:24] busy)
    else $error("busy late after resume");
  a_refuse_when_suspended: assert property (status_write_refused |-> suspend_flag)
    else $error("refusal while not suspended");
  a_span_aligned: assert property (op_erase |-> (op_base & op_span) == 24'h000000)
    else $error("erase base not aligned");
endmodule
bind fps_core fps_sva #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) i_sva (.clk, .arst_n, .busy,
  .write_enable_latch, .suspend_flag, .quad_enable_bit, .four_line_command_mode, .op_erase,
  .op_base, .op_span, .op_write, .status_write_refused);
`default_nettype wire

// *** dv/fps_host.sv ***
// fps_host.sv: host controller model driving the link pins
// assumes: clk at least 8 times the link clock
`timescale 1ns/100ps
`default_nettype none
module fps_host (
  input wire logic clk, // system clock
  output logic chip_select_n, // select, low active
  output logic serial_clock, // link clock, low outside frames
  output logic [3:0] data_line // data lines, bit 3 msb of nibble
);
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    data_line = 4'h5;
  end
  task automatic edge_bit(input logic [3:0] v);
    @(posedge clk) data_line <= v;
    repeat (4) @(posedge clk);
    serial_clock <= 1'b1;
    repeat (4) @(posedge clk);
    serial_clock <= 1'b0;
  endtask
  // na address bits, nd quad bytes high nibble first; select held low throughout
  task automatic xfer(input logic [7:0] op, input logic [23:0] adr, input int na,
    input logic [31:0] dat, input int nd);
    int i;
    @(posedge clk) chip_select_n <= 1'b0;
    for (i = 7; i >= 0; i--) edge_bit({3'h0, op[i]});
    for (i = 23; i > 23 - na; i--) edge_bit({3'h0, adr[i]});
    for (i = 0; i < 2 * nd; i++) edge_bit(dat[31 - 4 * i -: 4]);
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    data_line <= ~data_line;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// testbench.sv: self-checking bench of fps_core
// assumes: fps_core, fps_host and fps_sva compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic quad_en = 1'b0;
  logic four = 1'b0;
  logic [5:0] prot = 6'h00;
  wire logic cs_n;
  wire logic sck;
  wire logic [3:0] dl;
  logic busy, latch, susp, ers, wr, refused;
  logic [23:0] base, span;
  logic [7:0] data;
  logic [49:0] notes[$];
  int fails = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  fps_host i_host (.clk(clk), .chip_select_n(cs_n), .serial_clock(sck), .data_line(dl));
  fps_core #(.ERASE_CYCLES(32'd400), .CHIP_CYCLES(32'd600), .PROG_CYCLES(32'd20),
    .SUSPEND_CYCLES(32'd10)) i_dut (.clk(clk), .arst_n(arst_n), .chip_select_n(cs_n),
    .serial_clock(sck), .data_line_0(dl[0]), .data_line_1(dl[1]), .data_line_2(dl[2]),
    .data_line_3(dl[3]), .quad_enable_bit(quad_en), .four_line_command_mode(four),
    .protect_complement(prot[5]), .sector_granularity_select(prot[4]),
    .top_bottom_select(prot[3]), .block_protect_level_2(prot[2]),
    .block_protect_level_1(prot[1]), .block_protect_level_0(prot[0]),
    .array_top(23'h7FFFFF), .busy(busy), .write_enable_latch(latch), .suspend_flag(susp),
    .op_erase(ers), .op_base(base), .op_span(span), .op_write(wr), .op_data(data),
    .status_write_refused(refused));
  task automatic check(input logic [49:0] seen, input logic [49:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 3000, 1'b1);
  endtask
  task automatic wren();
    i_host.xfer(8'h06, 24'h0, 0, 32'h0, 0);
  endtask
  function automatic logic [49:0] seen_now();
    if (ers)
      return {2'h1, base, span};
    if (wr)
      return {2'h0, base, 16'h0000, data};
    return {2'h2, 48'h0};
  endfunction
  always @(negedge clk)
    if (ers || wr || refused)
      check(seen_now(), notes.size() ? notes.pop_front() : ~seen_now());
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end
  initial
  begin
    logic [7:0] ops [5];
    logic [23:0] spans [5];
    logic [23:0] a;
    logic [31:0] d;
    int k;
    ops = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    spans = '{24'h000FFF, 24'h007FFF, 24'h00FFFF, 24'h7FFFFF, 24'h7FFFFF};
    void'($urandom(83026));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (k = 0; k < 5; k++)
    begin
      a = 24'($urandom) & 24'h7FFFFF;
      wren();
      notes.push_back({2'h1, (k < 3) ? (a & ~spans[k]) : 24'h000000, spans[k]});
      i_host.xfer(ops[k], a, (k < 3) ? 24 : 0, 32'h0, 0);
      idle();
      check(latch, 1'b0);
    end
    $display("test erase kinds done");
    i_host.xfer(8'h20, a, 24, 32'h0, 0);
    check(busy, 1'b0);
    wren();
    i_host.xfer(8'h20, a, 23, 32'h0, 0);
    i_host.xfer(8'h52, a, 24, 32'h0, 1);
    i_host.xfer(8'hC7, a, 8, 32'h0, 0);
    prot <= 6'h07;
    i_host.xfer(8'hD8, a, 24, 32'h0, 0);
    i_host.xfer(8'h60, a, 0, 32'h0, 0);
    check({busy, latch}, 2'h1);
    prot <= 6'h00;
    i_host.xfer(8'h04, a, 0, 32'h0, 0);
    check(latch, 1'b0);
    wren();
    check(latch, 1'b1);
    $display("test refusals done");
    d = $urandom;
    i_host.xfer(8'h32, a, 24, d, 3);
    quad_en <= 1'b1;
    four <= 1'b1;
    i_host.xfer(8'h32, a, 24, d, 3);
    four <= 1'b0;
    for (k = 0; k < 3; k++)
      notes.push_back({2'h0, a[23:8], 8'hFE + 8'(k), 16'h0000, d[31 - 8 * k -: 8]});
    i_host.xfer(8'h32, a | 24'h0000FE, 24, d, 3);
    idle();
    check(latch, 1'b0);
    $display("test quad program done");
    wren();
    notes.push_back({2'h1, a & 24'hFFF000, 24'h000FFF});
    i_host.xfer(8'h20, a, 24, 32'h0, 0);
    i_host.xfer(8'h75, a, 0, 32'h0, 0);
    check(susp, 1'b1);
    idle();
    i_host.xfer(8'h20, a, 24, 32'h0, 0);
    notes.push_back({2'h2, 48'h0});
    i_host.xfer(8'h01, a, 0, 32'h0, 0);
    i_host.xfer(8'h7A, a, 0, 32'h0, 0);
    repeat (20) @(posedge clk);
    check({susp, busy}, 2'h1);
    idle();
    check(latch, 1'b0);
    $display("test suspend resume done");
    wren();
    notes.push_back({2'h1, 24'h000000, 24'h7FFFFF});
    i_host.xfer(8'hC7, a, 0, 32'h0, 0);
    i_host.xfer(8'h75, a, 0, 32'h0, 0);
    check({susp, busy}, 2'h1);
    idle();
    i_host.xfer(8'h7A, a, 0, 32'h0, 0);
    check({susp, busy}, 2'h0);
    wren();
    notes.push_back({2'h1, a & 24'hFFF000, 24'h000FFF});
    i_host.xfer(8'h20, a, 24, 32'h0, 0);
    i_host.xfer(8'h75, a, 0, 32'h0, 0);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({susp, busy, latch}, 3'h0);
    check(notes.size(), 0);
    $display("test chip and reset done");
    summarize();
  end
endmodule
`default_nettype wire
